/* File: hdl/mtc_pkg.sv */
`default_nettype none
package mtc_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_CLK   = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic [3:0] ADDR_LIMIT = 4'hC;
  // control/status bit positions
  localparam int BIT_OVF   = 7;
  localparam int BIT_IRQEN = 6;
  localparam int BIT_CLR   = 5;
  localparam int BIT_HALT  = 4;
  // clock config field positions
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int PRESC_HI = 3;
  localparam int PRESC_LO = 0;
  localparam logic [3:0] PRESC_MAX = 4'h8;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] LIMIT_FREE = 8'h00;
  localparam logic [7:0] COUNT_ONE  = 8'h01;
  typedef enum logic [1:0] {
    MTC_SRC_BUS  = 2'b00,
    MTC_SRC_FIX  = 2'b01,
    MTC_SRC_FALL = 2'b10,
    MTC_SRC_RISE = 2'b11
  } mtc_src_t;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

/* File: hdl/mtc_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module mtc_prescaler (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       src_tick,
  input  wire logic [3:0] prescale_select,
  output logic            count_tick
);
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic [3:0] presc_eff;
  logic       next_count_tick;

  // divider keeps running on a ratio change, so the count is untouched
  always_comb begin
    presc_eff = (prescale_select > mtc_pkg::PRESC_MAX) ? mtc_pkg::PRESC_MAX
                                                       : prescale_select;
    next_div_cnt = div_cnt;
    next_count_tick = 1'b0;
    if (src_tick) begin
      next_div_cnt = div_cnt + mtc_pkg::COUNT_ONE;
      // tick when the low presc_eff bits wrap
      next_count_tick = ((div_cnt & ((9'h001 << presc_eff) - 9'h001)) ==
                         (((9'h001 << presc_eff) - 9'h001) & 9'h0FF));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt    <= 8'h00;
      count_tick <= 1'b0;
    end else begin
      div_cnt    <= next_div_cnt;
      count_tick <= next_count_tick;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/mtc_timer.sv */
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module mtc_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fixed_freq_clock,
  input  wire logic        ext_tick_pin,
  output logic             timer_irq
);
  ////////////////////////////////////////////////////////////////////
  // bus phase capture
  logic       wr_pend;
  logic       rd_pend;
  logic [3:0] addr_q;
  logic       next_wr_pend;
  logic       next_rd_pend;
  logic [3:0] next_addr_q;
  logic       take;

  // upper address bits must be zero, otherwise words would alias
  assign take = hsel && hready && (htrans == mtc_pkg::HTRANS_NONSEQ) && (haddr[31:4] == '0);

  always_comb begin
    next_wr_pend = take && hwrite;
    next_rd_pend = take && !hwrite;
    next_addr_q  = take ? haddr[3:0] : addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 4'h0;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q  <= next_addr_q;
    end
  end

  logic wr_ctrl;
  logic wr_clk;
  logic wr_limit;
  always_comb begin
    wr_ctrl  = 1'b0;
    wr_clk   = 1'b0;
    wr_limit = 1'b0;
    if (wr_pend && addr_q == mtc_pkg::ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (wr_pend && addr_q == mtc_pkg::ADDR_CLK) begin
      wr_clk = 1'b1;
    end else if (wr_pend && addr_q == mtc_pkg::ADDR_LIMIT) begin
      wr_limit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tick pin synchroniser and source select
  logic [2:0] tick_sync;
  logic [1:0] fix_sync;
  logic       src_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_sync <= 3'h0;
      fix_sync  <= 2'h0;
    end else begin
      tick_sync <= {tick_sync[1:0], ext_tick_pin};
      fix_sync  <= {fix_sync[0], fixed_freq_clock};
    end
  end

  // fixed clock edge: history bit kept apart from the sync chain
  logic fix_prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fix_prev <= 1'b0;
    end else begin
      fix_prev <= fix_sync[1];
    end
  end

  logic [1:0] source_select;
  logic [3:0] prescale_select;

  always_comb begin
    case (mtc_pkg::mtc_src_t'(source_select))
      mtc_pkg::MTC_SRC_BUS:  src_tick = 1'b1;
      mtc_pkg::MTC_SRC_FIX:  src_tick = fix_sync[1] && !fix_prev;
      mtc_pkg::MTC_SRC_FALL: src_tick = tick_sync[2] && !tick_sync[1];
      default:               src_tick = !tick_sync[2] && tick_sync[1];
    endcase
  end

  logic count_tick;
  mtc_prescaler u_pre (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .src_tick        (src_tick),
    .prescale_select (prescale_select),
    .count_tick      (count_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // registers and counter
  logic       overflow_flag;
  logic       overflow_irq_enable;
  logic       counter_halt;
  logic       flag_armed;
  logic [7:0] count;
  logic [7:0] timer_limit;
  logic       next_overflow_flag;
  logic       next_overflow_irq_enable;
  logic       next_counter_halt;
  logic       next_flag_armed;
  logic [7:0] next_count;
  logic [7:0] next_limit;
  logic [1:0] next_source_select;
  logic [3:0] next_prescale_select;
  logic       wrap;
  logic       zap;
  logic       ovf_evt;

  always_comb begin
    zap  = (wr_ctrl && hwdata[mtc_pkg::BIT_CLR]) || wr_limit;
    wrap = count_tick && !counter_halt && (timer_limit != mtc_pkg::LIMIT_FREE)
           && (count == timer_limit);
    next_overflow_irq_enable = overflow_irq_enable;
    next_counter_halt        = counter_halt;
    next_source_select       = source_select;
    next_prescale_select     = prescale_select;
    next_limit               = timer_limit;
    next_count               = count;
    next_overflow_flag       = overflow_flag;
    next_flag_armed          = flag_armed;
    if (wr_ctrl) begin
      next_overflow_irq_enable = hwdata[mtc_pkg::BIT_IRQEN];
      next_counter_halt        = hwdata[mtc_pkg::BIT_HALT];
    end
    if (wr_clk) begin
      next_source_select   = hwdata[mtc_pkg::SRC_HI:mtc_pkg::SRC_LO];
      next_prescale_select = hwdata[mtc_pkg::PRESC_HI:mtc_pkg::PRESC_LO];
    end
    if (wr_limit) begin
      next_limit = hwdata[7:0];
    end
    // free run wraps naturally at 0xFF
    if (wrap) begin
      next_count = mtc_pkg::COUNT_ZERO;
    end else if (count_tick && !counter_halt) begin
      next_count = count + mtc_pkg::COUNT_ONE;
    end
    if (rd_pend && addr_q == mtc_pkg::ADDR_CTRL && overflow_flag) begin
      next_flag_armed = 1'b1;
    end
    if (wr_ctrl && !hwdata[mtc_pkg::BIT_OVF] && flag_armed) begin
      next_overflow_flag = 1'b0;
      next_flag_armed    = 1'b0;
    end
    if (zap) begin
      next_count         = mtc_pkg::COUNT_ZERO;
      next_overflow_flag = 1'b0;
      next_flag_armed    = 1'b0;
    end
    // a new overflow beats the read-then-write flag clear and disarms the sequence; a CLR or limit write beats the overflow
    ovf_evt = count_tick && !counter_halt && !zap &&
              (wrap || (timer_limit == mtc_pkg::LIMIT_FREE && count == 8'hFF));
    if (ovf_evt) begin
      next_overflow_flag = 1'b1;
      next_flag_armed    = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      counter_halt        <= 1'b1;
      flag_armed          <= 1'b0;
      count               <= mtc_pkg::COUNT_ZERO;
      timer_limit         <= mtc_pkg::LIMIT_FREE;
      source_select       <= 2'b00;
      prescale_select     <= 4'h0;
      timer_irq           <= 1'b0;
    end else begin
      overflow_flag       <= next_overflow_flag;
      overflow_irq_enable <= next_overflow_irq_enable;
      counter_halt        <= next_counter_halt;
      flag_armed          <= next_flag_armed;
      count               <= next_count;
      timer_limit         <= next_limit;
      source_select       <= next_source_select;
      prescale_select     <= next_prescale_select;
      timer_irq           <= next_overflow_flag && next_overflow_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, registered in the address phase
  logic [31:0] next_hrdata;
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (take && !hwrite && haddr[3:0] == mtc_pkg::ADDR_CTRL) begin
      next_hrdata[mtc_pkg::BIT_OVF]   = overflow_flag;
      next_hrdata[mtc_pkg::BIT_IRQEN] = overflow_irq_enable;
      next_hrdata[mtc_pkg::BIT_HALT]  = counter_halt;
    end else if (take && !hwrite && haddr[3:0] == mtc_pkg::ADDR_CLK) begin
      next_hrdata[mtc_pkg::SRC_HI:mtc_pkg::PRESC_LO] = {source_select, prescale_select};
    end else if (take && !hwrite && haddr[3:0] == mtc_pkg::ADDR_COUNT) begin
      next_hrdata[7:0] = count;
    end else if (take && !hwrite && haddr[3:0] == mtc_pkg::ADDR_LIMIT) begin
      next_hrdata[7:0] = timer_limit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence seq_ctrl_clear;
    wr_ctrl && hwdata[mtc_pkg::BIT_CLR];
  endsequence
  sequence seq_flag_read;
    rd_pend && addr_q == mtc_pkg::ADDR_CTRL && overflow_flag;
  endsequence
  sequence seq_zero_write;
    wr_ctrl && !hwdata[mtc_pkg::BIT_OVF];
  endsequence

  AST_CLR_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_ctrl_clear |=> (count == mtc_pkg::COUNT_ZERO && !overflow_flag))
    else $error("counter clear did not zero count and flag");
  AST_LIMIT_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_limit |=> (!overflow_flag && count == mtc_pkg::COUNT_ZERO))
    else $error("limit write did not clear flag");
  AST_WRAP_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    (wrap && !zap) |=> (overflow_flag && count == mtc_pkg::COUNT_ZERO))
    else $error("wrap did not set flag");
  AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_irq == (overflow_flag && overflow_irq_enable))
    else $error("irq mismatch");
  AST_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_flag_read ##0 !ovf_evt) |=> flag_armed)
    else $error("flag read did not arm the clear");
  AST_TWO_STEP_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (seq_zero_write ##0 (flag_armed && !ovf_evt)) |=> !overflow_flag)
    else $error("armed clear left the flag set");
  AST_OVF_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> overflow_flag)
    else $error("overflow did not set flag");
  AST_SRC_KEEPS: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_clk && !(count_tick && !counter_halt)) |=> $stable(count))
    else $error("clock config write moved count");
  AST_CNT_RO: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && addr_q == mtc_pkg::ADDR_COUNT && !(count_tick && !counter_halt))
    |=> $stable(count))
    else $error("count register write changed count");
  AST_HALT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (counter_halt && !zap) |=> $stable(count))
    else $error("halted counter moved");
  AST_NO_BLIND_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (overflow_flag && !flag_armed && !zap) |=> overflow_flag)
    else $error("flag cleared without prior read");
  AST_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (count_tick && !counter_halt && !zap && !wrap) |=> count == $past(count) + 8'h01)
    else $error("counter did not step");
  AST_RD_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr[3:0] == mtc_pkg::ADDR_CTRL) |=> hrdata[3:0] == 4'h0
    && hrdata[mtc_pkg::BIT_CLR] == 1'b0)
    else $error("unused bits read nonzero");
endmodule
`default_nettype wire

/* File: testbench/modulo_timer_ctrl_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none
module modulo_timer_ctrl_regs_test;
  localparam logic [7:0] a_ctl = {4'h0, mtc_pkg::ADDR_CTRL};
  localparam logic [7:0] a_clk = {4'h0, mtc_pkg::ADDR_CLK};
  localparam logic [7:0] a_cnt = {4'h0, mtc_pkg::ADDR_COUNT};
  localparam logic [7:0] a_lim = {4'h0, mtc_pkg::ADDR_LIMIT};
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic        tick      = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        timer_irq;
  logic [31:0] rd;
  logic [7:0]  cnt;
  int          miscompares = 0;
  int          cmp_count   = 0;

  always #50 hclk = ~hclk;

  // one stimulus line feeds both the fixed clock and the tick pin
  mtc_timer i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fixed_freq_clock(tick),
    .ext_tick_pin(tick), .timer_irq(timer_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= mtc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d});
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk_bit("hresp", 1'b0, hresp);
    cmp_count++;
    if (rd !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, rd);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask

  // pin kept at a quarter of the bus rate, as the synchroniser needs
  task automatic pulses(input int n);
    repeat (n) begin
      tick <= 1'b1;
      repeat (2) @(posedge hclk);
      tick <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    repeat (8) @(posedge hclk);
  endtask

  task automatic print_verdict;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctl_rst", a_ctl, 32'h10);
    rdc("clk_rst", a_clk, 32'h0);
    rdc("cnt_rst", a_cnt, 32'h0);
    rdc("lim_rst", a_lim, 32'h0);
    rdc("unmapped", 8'h10, 32'h0);
    wr(a_clk, 8'hFF);
    rdc("clk_unused", a_clk, 32'h3F);
    wr(a_ctl, 8'h2F);
    rdc("ctl_unused", a_ctl, 32'h0);
    cnt = 8'h00;
    for (int s = 1; s < 4; s++) begin
      wr(a_clk, {2'b00, s[1:0], 4'h0});
      pulses(2);
      cnt += 8'd2;
      rdc("src_count", a_cnt, {24'h0, cnt});
    end
    // two full periods give exactly two ticks whatever the divider phase
    for (int p = 0; p < 16; p++) begin
      wr(a_clk, {4'h3, p[3:0]});
      pulses(2 << ((p > 8) ? 8 : p));
      cnt += 8'd2;
      rdc("presc_count", a_cnt, {24'h0, cnt});
    end
    wr(a_clk, 8'h00);
    repeat (20) @(posedge hclk);
    wr(a_clk, 8'h30);
    bus(a_cnt, 1'b0, 32'h0);
    chk_bit("bus_src_moves", 1'b1, rd[7:0] > cnt);
    wr(a_lim, 8'h03);
    rdc("lim_zaps_cnt", a_cnt, 32'h0);
    rdc("lim_rb", a_lim, 32'h03);
    pulses(3);
    rdc("below_lim", a_ctl, 32'h0);
    pulses(1);
    wr(a_ctl, 8'h00);
    rdc("clr_no_read", a_ctl, 32'h80);
    rdc("wrapped", a_cnt, 32'h0);
    wr(a_ctl, 8'h00);
    rdc("clr_done", a_ctl, 32'h0);
    wr(a_ctl, 8'h40);
    chk_bit("irq_idle", 1'b0, timer_irq);
    pulses(4);
    chk_bit("irq_set", 1'b1, timer_irq);
    rdc("ovf_irq", a_ctl, 32'hC0);
    pulses(2);
    wr(a_ctl, 8'h60);
    rdc("clr_bit", a_ctl, 32'h40);
    rdc("clr_cnt", a_cnt, 32'h0);
    chk_bit("irq_off", 1'b0, timer_irq);
    pulses(4);
    wr(a_lim, 8'h03);
    rdc("lim_clr_ovf", a_ctl, 32'h40);
    wr(a_cnt, 8'hAA);
    rdc("cnt_ro", a_cnt, 32'h0);
    wr(a_ctl, 8'h10);
    pulses(2);
    rdc("halted", a_cnt, 32'h0);
    wr(a_ctl, 8'h00);
    pulses(1);
    rdc("resumed", a_cnt, 32'h1);
    wr(a_lim, 8'h00);
    pulses(255);
    rdc("free_ff", a_cnt, 32'hFF);
    rdc("free_noovf", a_ctl, 32'h00);
    pulses(1);
    rdc("free_wrap", a_ctl, 32'h80);
    print_verdict();
  end
endmodule
`default_nettype wire
